// file: expander_regs.svh
// offsets, reset values, field positions and timing counts of the serial register access port
// assumes it is included by bare name after the type package is compiled
`ifndef EXPANDER_REGS_SVH
`define EXPANDER_REGS_SVH

// ==========================================
// register indices
`define REG_IO_DIRECTION 4'h0
`define REG_INPUT_POLARITY 4'h1
`define REG_CHANGE_IRQ_ENABLE 4'h2
`define REG_COMPARE_DEFAULT 4'h3
`define REG_IRQ_COMPARE_CONTROL 4'h4
`define REG_DEVICE_CONFIG 4'h5
`define REG_PULLUP_ENABLE 4'h6
`define REG_IRQ_FLAG 4'h7
`define REG_IRQ_CAPTURE 4'h8
`define REG_PORT_VALUE 4'h9
`define REG_OUTPUT_LATCH 4'hA
`define REG_FIRST 4'h0
`define REG_LAST 4'hA
`define REG_COUNT 11

// ==========================================
// reset values and fields
`define RST_IO_DIRECTION 8'hFF
`define RST_DEFAULT 8'h00
`define SEQ_OP_BIT 5

// ==========================================
// timing
`define CLK_MHZ 50
`define DEC_ENABLE_DELAY_NS 2000
`define DEC_LATCH_DELAY_NS 1000
`define DEC_ENABLE_CYCLES ((`DEC_ENABLE_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define DEC_LATCH_CYCLES ((`DEC_LATCH_DELAY_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: expander_pkg.sv
// types shared by the serial register access port
// assumes nothing of its surroundings
package expander_pkg;

    typedef logic [3:0] reg_idx_t;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] hw_addr_t;
    typedef logic [6:0] level_t;

    // gray along idle, control, register, write data; read branch off control ack
    typedef enum logic [3:0] {
        TW_IDLE = 4'h0,
        TW_CTRL = 4'h1,
        TW_CTRL_ACK = 4'h3,
        TW_REG = 4'h2,
        TW_REG_ACK = 4'h6,
        TW_WDATA = 4'h7,
        TW_WDATA_ACK = 4'h5,
        TW_RDATA = 4'h4,
        TW_RDATA_ACK = 4'hC
    } tw_state_t;

endpackage : expander_pkg

// file: serial_register_access_port.sv
// serial register access port: two-wire client, spi client, register bank, address decoder
// assumes scl/sda/comparator pins are asynchronous and spi_sck is a separate clock
`timescale 1ns/10ps
`default_nettype none
`include "expander_regs.svh"

module serial_register_access_port #(
    parameter logic [3:0] TW_FIXED_ADDR = 4'h5,  // arbitrary value
    parameter logic [6:0] SPI_FIXED_ADDR = 7'h2A  // arbitrary value
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic tw_scl,
    input wire logic tw_sda_in,
    output logic tw_sda_out,
    output logic tw_sda_oe,
    input wire expander_pkg::level_t addr_level,
    output logic decoder_power,
    output expander_pkg::hw_addr_t client_hw_addr,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    output logic spi_so,
    output logic spi_so_oe,
    input wire expander_pkg::byte_t irq_flag_in,
    input wire expander_pkg::byte_t irq_capture_in,
    input wire expander_pkg::byte_t port_level_in,
    output expander_pkg::byte_t io_direction,
    output expander_pkg::byte_t input_polarity,
    output expander_pkg::byte_t change_irq_enable,
    output expander_pkg::byte_t compare_default,
    output expander_pkg::byte_t irq_compare_control,
    output expander_pkg::byte_t device_config,
    output expander_pkg::byte_t pullup_enable,
    output expander_pkg::byte_t output_latch
);
    import expander_pkg::*;
    // ==========================================
    // helpers
    function automatic reg_idx_t next_ptr(input reg_idx_t ptr, input logic fixed);
        next_ptr = fixed ? ptr : ((ptr >= `REG_LAST) ? `REG_FIRST : ptr + 4'h1);
    endfunction : next_ptr
    function automatic byte_t rd_byte(input logic [10:0][7:0] view, input reg_idx_t idx);
        rd_byte = (idx > `REG_LAST) ? 8'h00 : view[idx];
    endfunction : rd_byte
    function automatic logic writable(input reg_idx_t idx);
        writable = (idx <= `REG_LAST) && (idx != `REG_IRQ_FLAG) && (idx != `REG_IRQ_CAPTURE);
    endfunction : writable
    function automatic hw_addr_t therm_to_bin(input level_t t);
        therm_to_bin = 3'h0;
        for (int i = 0; i < 7; i++) begin
            therm_to_bin = therm_to_bin + {2'b00, t[i]};
        end
    endfunction : therm_to_bin
    // ==========================================
    // register bank
    logic [10:0][7:0] bank_q, rd_view;
    logic fixed_ptr, wr_en, tw_wr_q, spi_evt;
    reg_idx_t wr_idx, tw_wr_idx_q, spi_wr_idx_q;
    byte_t wr_data, tw_wr_data_q, spi_wr_data_q;
    // set bit means byte mode, so reset leaves auto-increment on
    assign fixed_ptr = bank_q[`REG_DEVICE_CONFIG][`SEQ_OP_BIT];
    always_comb begin
        rd_view = bank_q;
        rd_view[`REG_IRQ_FLAG] = irq_flag_in;
        rd_view[`REG_IRQ_CAPTURE] = irq_capture_in;
        rd_view[`REG_PORT_VALUE] = port_level_in;
    end
    always_comb begin
        wr_en = tw_wr_q | spi_evt;
        wr_idx = tw_wr_q ? tw_wr_idx_q : spi_wr_idx_q;
        wr_data = tw_wr_q ? tw_wr_data_q : spi_wr_data_q;
    end
    // writing the port value lands in the output latch
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bank_q <= '0;
            bank_q[`REG_IO_DIRECTION] <= `RST_IO_DIRECTION;
        end else if (wr_en && writable(wr_idx)) begin
            if (wr_idx == `REG_PORT_VALUE) begin
                bank_q[`REG_OUTPUT_LATCH] <= wr_data;
            end else begin
                bank_q[wr_idx] <= wr_data;
            end
        end
    end
    assign io_direction = bank_q[`REG_IO_DIRECTION];
    assign input_polarity = bank_q[`REG_INPUT_POLARITY];
    assign change_irq_enable = bank_q[`REG_CHANGE_IRQ_ENABLE];
    assign compare_default = bank_q[`REG_COMPARE_DEFAULT];
    assign irq_compare_control = bank_q[`REG_IRQ_COMPARE_CONTROL];
    assign device_config = bank_q[`REG_DEVICE_CONFIG];
    assign pullup_enable = bank_q[`REG_PULLUP_ENABLE];
    assign output_latch = bank_q[`REG_OUTPUT_LATCH];
    // ==========================================
    // pin synchronisers: bit0 scl, bit1 sda, bit2 spi write toggle, bits 9:3 comparators
    logic spi_wr_tgl_q, scl_rise, scl_fall, sda_f, tw_start, tw_stop;
    logic [9:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q, pin_prev_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // scl and sda idle high, so release shows no false edge
            pin_s1_q <= 10'h003;
            pin_s2_q <= 10'h003;
            pin_s3_q <= 10'h003;
            pin_f_q <= 10'h003;
            pin_prev_q <= 10'h003;
        end else begin
            pin_s1_q <= {addr_level, spi_wr_tgl_q, tw_sda_in, tw_scl};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            // a change counts only once stages two and three agree
            pin_f_q <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
            pin_prev_q <= pin_f_q;
        end
    end

    assign sda_f = pin_f_q[1];
    assign scl_rise = pin_f_q[0] & ~pin_prev_q[0];
    assign scl_fall = ~pin_f_q[0] & pin_prev_q[0];
    assign tw_start = pin_f_q[0] & pin_prev_q[0] & ~pin_f_q[1] & pin_prev_q[1];
    assign tw_stop = pin_f_q[0] & pin_prev_q[0] & pin_f_q[1] & ~pin_prev_q[1];
    assign spi_evt = pin_f_q[2] ^ pin_prev_q[2];
    // ==========================================
    // address decoder
    logic [15:0] dec_cnt_q;
    logic dec_on_q, dec_latched_q;
    hw_addr_t hw_addr_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dec_cnt_q <= 16'h0000;
            dec_on_q <= 1'b0;
            dec_latched_q <= 1'b0;
            hw_addr_q <= 3'h0;
        end else if (!dec_latched_q) begin
            dec_cnt_q <= dec_cnt_q + 16'h0001;
            if (dec_cnt_q == 16'(`DEC_ENABLE_CYCLES)) begin
                dec_on_q <= 1'b1;
            end
            if (dec_cnt_q == 16'(`DEC_ENABLE_CYCLES + `DEC_LATCH_CYCLES)) begin
                hw_addr_q <= therm_to_bin(pin_f_q[9:3]);
                dec_latched_q <= 1'b1;
            end
        end else if (scl_rise) begin
            dec_on_q <= 1'b0;
        end
    end
    assign decoder_power = dec_on_q;
    assign client_hw_addr = hw_addr_q;
    // ==========================================
    // two-wire client
    tw_state_t tw_st_q;
    logic [2:0] tw_cnt_q;
    byte_t tw_sh_q, tw_out_q, tw_byte, tw_load;
    reg_idx_t tw_ptr_q;
    logic tw_rd_q, tw_ack_q, tw_oe_q, tw_zero_q;
    assign tw_byte = {tw_sh_q[6:0], sda_f};
    assign tw_load = rd_byte(rd_view, tw_ptr_q);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tw_st_q <= TW_IDLE;
            tw_cnt_q <= 3'h0;
            tw_sh_q <= 8'h00;
            tw_out_q <= 8'h00;
            tw_ptr_q <= `REG_FIRST;
            tw_rd_q <= 1'b0;
            tw_ack_q <= 1'b0;
            tw_oe_q <= 1'b0;
            tw_wr_q <= 1'b0;
            tw_wr_idx_q <= `REG_FIRST;
            tw_wr_data_q <= 8'h00;
        end else begin
            tw_wr_q <= 1'b0;
            if (tw_start) begin
                // a partial byte is dropped by never reaching the commit
                tw_st_q <= TW_CTRL;
                tw_cnt_q <= 3'h0;
                tw_ack_q <= 1'b0;
                tw_oe_q <= 1'b0;
            end else if (tw_stop) begin
                tw_st_q <= TW_IDLE;
                tw_ack_q <= 1'b0;
                tw_oe_q <= 1'b0;
            end else if (scl_rise) begin
                unique case (tw_st_q)
                    TW_CTRL, TW_REG, TW_WDATA: begin
                        tw_sh_q <= tw_byte;
                        tw_cnt_q <= tw_cnt_q + 3'h1;
                        if (tw_cnt_q == 3'h7) begin
                            if (tw_st_q == TW_CTRL) begin
                                tw_rd_q <= tw_byte[0];
                                if (tw_byte[7:1] == {TW_FIXED_ADDR, hw_addr_q}) begin
                                    tw_st_q <= TW_CTRL_ACK;
                                end else begin
                                    tw_st_q <= TW_IDLE;
                                end
                            end else if (tw_st_q == TW_REG) begin
                                tw_ptr_q <= tw_byte[3:0];
                                tw_st_q <= TW_REG_ACK;
                            end else begin
                                tw_wr_q <= 1'b1;
                                tw_wr_idx_q <= tw_ptr_q;
                                tw_wr_data_q <= tw_byte;
                                tw_st_q <= TW_WDATA_ACK;
                            end
                        end
                    end
                    TW_RDATA: begin
                        tw_cnt_q <= tw_cnt_q + 3'h1;
                    end
                    TW_RDATA_ACK: begin
                        if (sda_f) begin
                            tw_st_q <= TW_IDLE;
                        end else begin
                            tw_ptr_q <= next_ptr(tw_ptr_q, fixed_ptr);
                            tw_ack_q <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                unique case (tw_st_q)
                    TW_CTRL_ACK, TW_REG_ACK, TW_WDATA_ACK: begin
                        if (!tw_ack_q) begin
                            tw_oe_q <= 1'b1;
                            tw_ack_q <= 1'b1;
                        end else begin
                            tw_oe_q <= 1'b0;
                            tw_ack_q <= 1'b0;
                            tw_cnt_q <= 3'h0;
                            if (tw_st_q == TW_CTRL_ACK && tw_rd_q) begin
                                tw_out_q <= tw_load;
                                tw_oe_q <= ~tw_load[7];
                                tw_st_q <= TW_RDATA;
                            end else if (tw_st_q == TW_CTRL_ACK) begin
                                tw_st_q <= TW_REG;
                            end else if (tw_st_q == TW_REG_ACK) begin
                                tw_st_q <= TW_WDATA;
                            end else begin
                                tw_ptr_q <= next_ptr(tw_ptr_q, fixed_ptr);
                                tw_st_q <= TW_WDATA;
                            end
                        end
                    end
                    TW_RDATA: begin
                        if (tw_cnt_q == 3'h0) begin
                            tw_oe_q <= 1'b0;
                            tw_st_q <= TW_RDATA_ACK;
                        end else begin
                            tw_out_q <= {tw_out_q[6:0], 1'b0};
                            tw_oe_q <= ~tw_out_q[6];
                        end
                    end
                    TW_RDATA_ACK: begin
                        if (tw_ack_q) begin
                            tw_ack_q <= 1'b0;
                            tw_out_q <= tw_load;
                            tw_oe_q <= ~tw_load[7];
                            tw_st_q <= TW_RDATA;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
    // open drain: the data level is always low, only the enable moves
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tw_zero_q <= 1'b0;
        end else begin
            tw_zero_q <= 1'b0;
        end
    end
    assign tw_sda_out = tw_zero_q;
    assign tw_sda_oe = tw_oe_q;
    // ==========================================
    // spi client, on the link clock; deselect clears the frame
    logic spi_rst, spi_match_q, spi_rd_q, spi_oe_q;
    logic [2:0] spi_cnt_q;
    logic [1:0] spi_phase_q;
    logic [6:0] spi_sh_q;
    byte_t spi_byte, spi_out_q;
    reg_idx_t spi_ptr_q;
    assign spi_rst = rst | spi_cs_n;
    assign spi_byte = {spi_sh_q, spi_si};
    always_ff @(posedge spi_sck or posedge spi_rst) begin
        if (spi_rst) begin
            spi_cnt_q <= 3'h0;
            spi_phase_q <= 2'h0;
            spi_sh_q <= 7'h00;
            spi_ptr_q <= `REG_FIRST;
            spi_match_q <= 1'b0;
            spi_rd_q <= 1'b0;
        end else begin
            spi_sh_q <= spi_byte[6:0];
            spi_cnt_q <= spi_cnt_q + 3'h1;
            if (spi_cnt_q == 3'h7) begin
                unique case (spi_phase_q)
                    2'h0: begin
                        spi_match_q <= (spi_byte[7:1] == SPI_FIXED_ADDR);
                        spi_rd_q <= spi_byte[0];
                        spi_phase_q <= 2'h1;
                    end
                    2'h1: begin
                        spi_ptr_q <= spi_byte[3:0];
                        spi_phase_q <= 2'h2;
                    end
                    default: begin
                        spi_ptr_q <= next_ptr(spi_ptr_q, fixed_ptr);
                    end
                endcase
            end
        end
    end
    // write words stay put for a whole byte, so the toggle alone needs syncing
    always_ff @(posedge spi_sck or posedge rst) begin
        if (rst) begin
            spi_wr_tgl_q <= 1'b0;
            spi_wr_idx_q <= `REG_FIRST;
            spi_wr_data_q <= 8'h00;
        end else if (!spi_cs_n && spi_cnt_q == 3'h7 && spi_phase_q == 2'h2 && spi_match_q && !spi_rd_q) begin
            spi_wr_tgl_q <= ~spi_wr_tgl_q;
            spi_wr_idx_q <= spi_ptr_q;
            spi_wr_data_q <= spi_byte;
        end
    end
    // bank is quasi-static during a frame; a limitation is that port inputs may move under it
    always_ff @(negedge spi_sck or posedge spi_rst) begin
        if (spi_rst) begin
            spi_out_q <= 8'h00;
            spi_oe_q <= 1'b0;
        end else if (spi_cnt_q == 3'h0 && spi_phase_q == 2'h2 && spi_match_q && spi_rd_q) begin
            spi_out_q <= rd_byte(rd_view, spi_ptr_q);
            spi_oe_q <= 1'b1;
        end else begin
            spi_out_q <= {spi_out_q[6:0], 1'b0};
        end
    end
    assign spi_so = spi_out_q[7];
    assign spi_so_oe = spi_oe_q;

endmodule : serial_register_access_port
`default_nettype wire

// file: serial_register_access_port_props.sv
// assertions on the pins of the serial register access port
// assumes it is bound into serial_register_access_port, one clock domain
`timescale 1ns/10ps
`default_nettype none
module access_port_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic tw_scl,
    input wire logic tw_sda_out,
    input wire logic tw_sda_oe,
    input wire expander_pkg::level_t addr_level,
    input wire logic decoder_power,
    input wire expander_pkg::hw_addr_t client_hw_addr,
    input wire logic spi_cs_n,
    input wire logic spi_so_oe,
    input wire expander_pkg::byte_t io_direction,
    input wire expander_pkg::byte_t device_config
);
    import expander_pkg::*;
    // ====================
    // cycles since reset release, saturating so it never wraps
    logic [7:0] age_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            age_q <= 8'h00;
        end else if (age_q != 8'hFF) begin
            age_q <= age_q + 8'h01;
        end
    end
    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (rst);
    property p_reset_state; age_q == 8'h00 |-> io_direction == 8'hFF && !device_config[5] && !tw_sda_oe; endproperty
    a_reset_state: assert property (p_reset_state) else $error("not in reset state");
    property p_dec_early; age_q < 8'h5A |-> !decoder_power; endproperty
    a_dec_early: assert property (p_dec_early) else $error("decoder on too early");
    property p_dec_on; age_q == 8'h8C |-> decoder_power; endproperty
    a_dec_on: assert property (p_dec_on) else $error("decoder not on");
    property p_addr_code; age_q == 8'hAA |-> client_hw_addr == 3'($countones(addr_level)); endproperty
    a_addr_code: assert property (p_addr_code) else $error("address code wrong");
    property p_addr_hold; age_q > 8'hAA |-> $stable(client_hw_addr); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_so_idle; spi_cs_n |-> !spi_so_oe; endproperty
    a_so_idle: assert property (p_so_idle) else $error("so driven while deselected");
    property p_ack_after_dec; tw_sda_oe |-> !decoder_power; endproperty
    a_ack_after_dec: assert property (p_ack_after_dec) else $error("decoder still on");
    // sda may only move while scl is low, else it reads as start or stop
    property p_sda_steady; $changed(tw_sda_oe) |-> !tw_scl; endproperty
    a_sda_steady: assert property (p_sda_steady) else $error("sda moved with scl high");
    property p_open_drain; tw_sda_oe |-> !tw_sda_out; endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda driven high");
    c_spi_read: cover property ($rose(spi_so_oe));
    c_ack: cover property ($rose(tw_sda_oe));
    c_dec_off: cover property ($fell(decoder_power));
endmodule : access_port_props
bind serial_register_access_port access_port_props chk_u (
    .clock(clock), .rst(rst), .tw_scl(tw_scl), .tw_sda_out(tw_sda_out), .tw_sda_oe(tw_sda_oe),
    .addr_level(addr_level), .decoder_power(decoder_power), .client_hw_addr(client_hw_addr),
    .spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe), .io_direction(io_direction), .device_config(device_config)
);
`default_nettype wire

// file: host_model.sv
// host controller model for the two-wire and spi sides
// assumes sda pull-up is resolved by the bench; so has no pull
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic sda_wire,
    input wire logic spi_so,
    input wire logic spi_so_oe,
    output logic tw_scl,
    output logic sda_drive,
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_si
);
    import expander_pkg::*;
    // ====================
    // quarter bit of 200 ns keeps sda edges well clear of scl through the pin filters
    wire logic so_seen = spi_so_oe ? spi_so : ~spi_so;
    initial begin
        tw_scl = 1'b1;
        sda_drive = 1'b1;
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end
    task automatic tw_bit(input logic b, output logic r);
        #200 sda_drive = b;
        #200 tw_scl = 1'b1;
        #200 r = sda_wire;
        #200 tw_scl = 1'b0;
    endtask : tw_bit
    task automatic tw_start();
        #200 sda_drive = 1'b1;
        #200 tw_scl = 1'b1;
        #200 sda_drive = 1'b0;
        #200 tw_scl = 1'b0;
    endtask : tw_start
    task automatic tw_stop();
        #200 sda_drive = 1'b0;
        #200 tw_scl = 1'b1;
        #200 sda_drive = 1'b1;
        #200;
    endtask : tw_stop
    task automatic tw_byte(input byte_t d, input logic a, output byte_t r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            tw_bit(d[i], r[i]);
        end
        tw_bit(a, ack);
    endtask : tw_byte
    // sck idles at cpol and only runs while selected
    task automatic spi_frame(input logic cpol, input byte_t tx[$], output byte_t rx[$]);
        byte_t r;
        rx = {};
        spi_sck = cpol;
        #37 spi_cs_n = 1'b0;
        foreach (tx[k]) begin
            for (int i = 7; i >= 0; i--) begin
                #40 spi_sck = 1'b0;
                spi_si = tx[k][i];
                #40 spi_sck = 1'b1;
                r[i] = so_seen;
            end
            rx.push_back(r);
        end
        #40 spi_sck = cpol;
        #40 spi_cs_n = 1'b1;
        spi_si = ~spi_si;
    endtask : spi_frame
endmodule : host_model
`default_nettype wire

// file: tb.sv
// self-checking bench for the serial register access port
// assumes host_model and the bound checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
module tb;
    import expander_pkg::*;
    localparam logic [3:0] TW_ID = 4'h5; // arbitrary value
    localparam logic [6:0] SPI_ID = 7'h2A; // arbitrary value
    localparam byte_t OPW = {SPI_ID, 1'b0};
    localparam byte_t OPR = {SPI_ID, 1'b1};
    typedef struct {reg_idx_t idx; byte_t wd; byte_t exp;} row_t;
    logic clock, rst, tw_scl, sda_drive, sda_wire, tw_sda_out, tw_sda_oe, decoder_power;
    logic spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe;
    level_t addr_level;
    hw_addr_t client_hw_addr, hw_exp;
    byte_t flag_in, cap_in, pin_in, io_direction, input_polarity, change_irq_enable, compare_default;
    byte_t irq_compare_control, device_config, pullup_enable, output_latch;
    byte_t rq[$];
    int failures, checked;
    row_t rows[11] = '{'{4'h0, 8'h0F, 8'h0F}, '{4'h1, 8'h11, 8'h11}, '{4'h2, 8'h22, 8'h22},
        '{4'h3, 8'h33, 8'h33}, '{4'h4, 8'h44, 8'h44}, '{4'h5, 8'h12, 8'h12}, '{4'h6, 8'h66, 8'h66},
        '{4'h7, 8'h77, 8'h3C}, '{4'h8, 8'h88, 8'hC3}, '{4'h9, 8'h99, 8'h5A}, '{4'hA, 8'hAA, 8'hAA}};
    serial_register_access_port #(.TW_FIXED_ADDR(TW_ID), .SPI_FIXED_ADDR(SPI_ID)) dut_u (
        .clock(clock), .rst(rst), .tw_scl(tw_scl), .tw_sda_in(sda_wire), .tw_sda_out(tw_sda_out),
        .tw_sda_oe(tw_sda_oe), .addr_level(addr_level), .decoder_power(decoder_power),
        .client_hw_addr(client_hw_addr), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
        .spi_so(spi_so), .spi_so_oe(spi_so_oe), .irq_flag_in(flag_in), .irq_capture_in(cap_in),
        .port_level_in(pin_in), .io_direction(io_direction), .input_polarity(input_polarity),
        .change_irq_enable(change_irq_enable), .compare_default(compare_default),
        .irq_compare_control(irq_compare_control), .device_config(device_config),
        .pullup_enable(pullup_enable), .output_latch(output_latch));
    host_model host_u (.sda_wire(sda_wire), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .tw_scl(tw_scl),
        .sda_drive(sda_drive), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si));
    // sda is pulled up; either party may pull it low
    assign sda_wire = sda_drive & ~(tw_sda_oe & ~tw_sda_out);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        #1_500_000;
        failures++;
        final_report();
    end
    // ====================
    // tasks
    task automatic chk(input string what, input byte_t exp, input byte_t got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk(what, {7'h00, exp}, {7'h00, got});
    endtask : chk_bit
    task automatic final_report();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    function automatic byte_t twc(input logic rw);
        return {TW_ID, hw_exp, rw};
    endfunction : twc
    task automatic reset_and_wait();
        @(negedge clock);
        rst = 1'b1;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        repeat (200) @(negedge clock);
    endtask : reset_and_wait
    task automatic tw_wr(input byte_t ctrl, input byte_t q[$], input logic nak);
        byte_t r;
        logic a;
        host_u.tw_start();
        host_u.tw_byte(ctrl, 1'b1, r, a);
        chk_bit("ctrl ack", nak, a);
        foreach (q[k]) begin
            host_u.tw_byte(q[k], 1'b1, r, a);
            chk_bit("byte ack", nak, a);
        end
        host_u.tw_stop();
    endtask : tw_wr
    task automatic tw_rd(input byte_t idx, input int n);
        byte_t r;
        logic a;
        rq = {};
        host_u.tw_start();
        host_u.tw_byte(twc(1'b0), 1'b1, r, a);
        host_u.tw_byte(idx, 1'b1, r, a);
        host_u.tw_start();
        host_u.tw_byte(twc(1'b1), 1'b1, r, a);
        chk_bit("read ack", 1'b0, a);
        for (int k = 0; k < n; k++) begin
            host_u.tw_byte(8'hFF, k == n - 1, r, a);
            rq.push_back(r);
        end
        host_u.tw_stop();
    endtask : tw_rd
    task automatic spi(input logic cpol, input byte_t op, input byte_t idx, input byte_t d[$]);
        byte_t tx[$];
        byte_t rx[$];
        tx = d;
        tx.push_front(idx);
        tx.push_front(op);
        host_u.spi_frame(cpol, tx, rx);
        rq = rx[2:$];
        repeat (10) @(negedge clock);
    endtask : spi
    // ====================
    // main sequence
    initial begin
        byte_t r;
        logic a;
        rst = 1'b1;
        addr_level = 7'h1F;
        hw_exp = 3'h5;
        flag_in = 8'h3C;
        cap_in = 8'hC3;
        pin_in = 8'h5A;
        failures = 0;
        checked = 0;
        reset_and_wait();
        chk("io_direction", 8'hFF, io_direction);
        chk("device_config", 8'h00, device_config);
        chk("hw addr", 8'(hw_exp), 8'(client_hw_addr));
        foreach (rows[i]) begin
            tw_wr(twc(1'b0), '{{4'h0, rows[i].idx}, rows[i].wd}, 1'b0);
            spi(rows[i].idx[0], OPR, {4'h0, rows[i].idx}, '{8'hFF});
            chk("row read", rows[i].exp, rq[0]);
        end
        tw_wr(twc(1'b0), '{8'h0A, 8'h01, 8'h02}, 1'b0);
        chk("output_latch", 8'h01, output_latch);
        chk("io_direction", 8'h02, io_direction);
        spi(1'b0, OPR, 8'h0A, '{8'hFF, 8'hFF});
        chk("spi wrap 0", 8'h01, rq[0]);
        chk("spi wrap 1", 8'h02, rq[1]);
        tw_wr(twc(1'b0), '{8'h07, 8'hEE, 8'hEE, 8'h5C}, 1'b0);
        chk("output_latch", 8'h5C, output_latch);
        host_u.tw_start();
        host_u.tw_byte(twc(1'b0), 1'b1, r, a);
        host_u.tw_byte(8'h02, 1'b1, r, a);
        for (int i = 0; i < 4; i++) host_u.tw_bit(1'b1, a);
        host_u.tw_stop();
        chk("change_irq_enable", 8'h22, change_irq_enable);
        spi(1'b1, OPW, 8'h05, '{8'h20});
        chk("device_config", 8'h20, device_config);
        tw_rd(8'h03, 3);
        foreach (rq[k]) chk("fixed read", 8'h33, rq[k]);
        tw_wr(twc(1'b0), '{8'h01, 8'hB1, 8'hB2}, 1'b0);
        chk("input_polarity", 8'hB2, input_polarity);
        chk("change_irq_enable", 8'h22, change_irq_enable);
        spi(1'b0, OPW, 8'h05, '{8'h00});
        tw_rd(8'h04, 2);
        chk("auto read 0", 8'h44, rq[0]);
        chk("auto read 1", 8'h00, rq[1]);
        tw_wr(twc(1'b0) ^ 8'h02, '{8'h00, 8'h77}, 1'b1);
        spi(1'b0, OPW ^ 8'h04, 8'h00, '{8'h77});
        chk("io_direction", 8'h02, io_direction);
        @(negedge clock);
        addr_level = 7'h07;
        repeat (20) @(negedge clock);
        chk("hw addr held", 8'(hw_exp), 8'(client_hw_addr));
        hw_exp = 3'h3;
        reset_and_wait();
        chk("hw addr", 8'(hw_exp), 8'(client_hw_addr));
        chk("io_direction", 8'hFF, io_direction);
        tw_wr(twc(1'b0), '{8'h00, 8'h81}, 1'b0);
        chk("io_direction", 8'h81, io_direction);
        final_report();
    end
endmodule : tb
`default_nettype wire
